// *** hw/sm_pkg.sv ***
/*
  shared constants and types of the safety monitor and its host controller.
  assumes a 10 MHz ref_clk on both ends.
*/
package sm_pkg;
  // rail counts: switching and linear rails
  localparam int NSW = 7;
  localparam int NLDO = 4;
  localparam int NRAIL = NSW + NLDO;

  // timing
  localparam int CLK_NS = 100;
  localparam int BLANK_MAX_US = 200;
  localparam int BLANK_MAX_CYC = BLANK_MAX_US * 1000 / CLK_NS;
  // four checks per rail; longest time, rounded down
  localparam int STEP_CYC = BLANK_MAX_CYC / (4 * NRAIL);
  localparam logic [7:0] STEP_LAST = 8'(STEP_CYC - 1);

  // device register map
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_IRQ_MASK = 4'h1;
  localparam logic [3:0] A_CTRL = 4'h2;
  localparam logic [3:0] A_SW_OV = 4'h3;
  localparam logic [3:0] A_LIN_OV = 4'h4;
  localparam logic [3:0] A_SW_UV = 4'h5;
  localparam logic [3:0] A_LIN_UV = 4'h6;

  // status fields
  localparam int B_REF_FAIL_STATUS = 0;
  localparam int B_REF_FAIL_IRQ_FLAG = 1;
  localparam int B_REG_ON = 2;
  localparam int B_SELF_TEST_FAIL = 3;
  // control fields
  localparam int B_SELF_TEST_RUN = 0;
  // reset values
  localparam logic IRQ_MASK_RST = 1'b0;

  // host APB map
  localparam logic [7:0] H_CMD = 8'h00;
  localparam logic [7:0] H_STAT = 8'h04;
  localparam int C_WDATA_LSB = 0;
  localparam int C_ADDR_LSB = 8;
  localparam int C_WRITE = 12;
  localparam int C_SECURE = 13;
  localparam int S_BUSY = 0;
  localparam int S_RDATA_LSB = 8;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_PU_TEST = 3'b001,
    ST_ON = 3'b010,
    ST_DEMAND = 3'b011,
    ST_FAIL = 3'b100
  } dev_state_t;
endpackage

// *** hw/sm_link_if.sv ***
/*
  register link between the host controller and the safety monitor.
  assumes both ends run on the same ref_clk.
*/
`timescale 1ns/100ps
interface sm_link_if;
  logic [3:0] regAddr;
  logic [7:0] regWdata;
  logic regWr;
  logic regRd;
  logic regSecure;
  logic [7:0] regRdata;
  logic regAck;

  modport dev (
    input regAddr, regWdata, regWr, regRd, regSecure,
    output regRdata, regAck
  );
  modport host (
    output regAddr, regWdata, regWr, regRd, regSecure,
    input regRdata, regAck
  );
endinterface

// *** hw/sm_device.sv ***
/*
  safety monitor: reference cross-check and self-test of rail comparators,
  with its register file on the link.
  assumes analog inputs are asynchronous and the host keeps a request up
  until it sees regAck.
*/
// Behaviour
// - compare regulator and monitor references continuously
// - reference mismatch is a critical fault
// - mismatch blocks switching regulator power-up
// - mismatch in power-up test fails, ignores bypass
// - system on, bypass 0: drift shuts regulators
// - system on, bypass 1: drift only interrupts
// - reference failure sets irq flag; mask only gates irq output
// - status bit tracks live mismatch
// - test every rail's overvoltage and undervoltage comparator
// - comparator not toggling sets its rail flag
// - four flag registers by kind and rail
// - every test run clears flags first
// - flags cleared by write only if secure or secureEnIn low
// - power-up continues after test, flags stay
// - run bit one starts full self-test
// - run bit self-clears when test ends
// - host starts test with secure write
// - on-demand blanking lasts at most 200 us
// - host ensures safe state before test
// - on-demand failures set matching flags
// - host reads flags after every test
`timescale 1ns/100ps
module sm_device (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register link
  sm_link_if.dev link,
  // analog side
  input wire logic refMismatchIn,
  input wire logic [sm_pkg::NRAIL-1:0] ovCmpIn,
  input wire logic [sm_pkg::NRAIL-1:0] uvCmpIn,
  output logic [sm_pkg::NRAIL-1:0] ovForce,
  output logic [sm_pkg::NRAIL-1:0] uvForce,
  // system side
  input wire logic powerUpReqIn,
  input wire logic bypassCfgIn,
  input wire logic secureEnIn,
  output logic regEnable,
  output logic monitorBlank,
  output logic selfTestFail,
  output logic irqOut
);
  import sm_pkg::*;

  typedef struct packed {
    logic [1:0] refSync;
    logic [1:0] puSync;
    logic [1:0] bypSync;
    logic [1:0] secSync;
    logic [NRAIL-1:0] ovSyncA;
    logic [NRAIL-1:0] ovSyncB;
    logic [NRAIL-1:0] uvSyncA;
    logic [NRAIL-1:0] uvSyncB;
    dev_state_t st;
    logic testing;
    logic [3:0] rail;
    logic [1:0] phase;
    logic [7:0] cnt;
    logic [NRAIL-1:0] ovFlags;
    logic [NRAIL-1:0] uvFlags;
    logic irqFlag;
    logic irqMask;
    logic testFail;
    logic regOn;
    logic blank;
    logic irq;
    logic [NRAIL-1:0] ovFrc;
    logic [NRAIL-1:0] uvFrc;
    logic ack;
    logic [7:0] rdata;
  } dev_t;

  dev_t s;
  dev_t next_s;
  logic refBad;
  logic bypass;
  logic secEn;
  logic access;
  logic flagWrOk;
  logic launch;
  logic done;
  logic cmpNow;
  logic [NRAIL-1:0] railBit;

  assign refBad = s.refSync[1];
  assign bypass = s.bypSync[1];
  assign secEn = s.secSync[1];

  always_comb begin
    next_s = s;
    launch = 1'b0;
    done = 1'b0;
    cmpNow = 1'b0;
    railBit = '0;
    // two-flop synchronisers on every analog and system input
    next_s.refSync = {s.refSync[0], refMismatchIn};
    next_s.puSync = {s.puSync[0], powerUpReqIn};
    next_s.bypSync = {s.bypSync[0], bypassCfgIn};
    next_s.secSync = {s.secSync[0], secureEnIn};
    next_s.ovSyncA = ovCmpIn;
    next_s.ovSyncB = s.ovSyncA;
    next_s.uvSyncA = uvCmpIn;
    next_s.uvSyncB = s.uvSyncA;

    // register access, one ack per request
    access = (link.regWr | link.regRd) & ~s.ack;
    flagWrOk = ~secEn | link.regSecure;
    next_s.ack = access;
    if (access) begin
      case (link.regAddr)
        A_STATUS: next_s.rdata = {4'h0, s.testFail, s.regOn, s.irqFlag, refBad};
        A_IRQ_MASK: next_s.rdata = {7'h00, s.irqMask};
        A_CTRL: next_s.rdata = {7'h00, s.st == ST_DEMAND};
        A_SW_OV: next_s.rdata = 8'(s.ovFlags[NSW-1:0]);
        A_LIN_OV: next_s.rdata = 8'(s.ovFlags[NRAIL-1:NSW]);
        A_SW_UV: next_s.rdata = 8'(s.uvFlags[NSW-1:0]);
        A_LIN_UV: next_s.rdata = 8'(s.uvFlags[NRAIL-1:NSW]);
        default: next_s.rdata = 8'h00;
      endcase
      if (link.regWr) begin
        case (link.regAddr)
          A_STATUS: begin
            if (link.regWdata[B_REF_FAIL_IRQ_FLAG]) begin
              next_s.irqFlag = 1'b0;
            end
          end
          A_IRQ_MASK: next_s.irqMask = link.regWdata[0];
          A_CTRL: begin
            // only a 1 while idle in system-on starts a test
            if (link.regWdata[B_SELF_TEST_RUN] && s.st == ST_ON && flagWrOk) begin
              launch = 1'b1;
              next_s.st = ST_DEMAND;
            end
          end
          A_SW_OV: begin
            if (flagWrOk) begin
              next_s.ovFlags[NSW-1:0] = s.ovFlags[NSW-1:0] & ~link.regWdata[NSW-1:0];
            end
          end
          A_LIN_OV: begin
            if (flagWrOk) begin
              next_s.ovFlags[NRAIL-1:NSW] = s.ovFlags[NRAIL-1:NSW] & ~link.regWdata[NLDO-1:0];
            end
          end
          A_SW_UV: begin
            if (flagWrOk) begin
              next_s.uvFlags[NSW-1:0] = s.uvFlags[NSW-1:0] & ~link.regWdata[NSW-1:0];
            end
          end
          A_LIN_UV: begin
            if (flagWrOk) begin
              next_s.uvFlags[NRAIL-1:NSW] = s.uvFlags[NRAIL-1:NSW] & ~link.regWdata[NLDO-1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end

    // power-up request from off
    if (s.st == ST_OFF && s.puSync[1] && !refBad) begin
      launch = 1'b1;
      next_s.st = ST_PU_TEST;
      next_s.testFail = 1'b0;
    end

    // self-test engine: force, wait, check each comparator in both senses
    if (s.testing) begin
      railBit = NRAIL'(1) << s.rail;
      next_s.cnt = s.cnt + 8'h01;
      if (s.cnt == STEP_LAST) begin
        next_s.cnt = 8'h00;
        cmpNow = s.phase[1] ? s.uvSyncB[s.rail] : s.ovSyncB[s.rail];
        // phase 0/2 expects a trip, phase 1/3 expects release
        if (cmpNow != ~s.phase[0]) begin
          if (s.phase[1]) begin
            next_s.uvFlags = next_s.uvFlags | railBit;
          end else begin
            next_s.ovFlags = next_s.ovFlags | railBit;
          end
        end
        next_s.phase = s.phase + 2'd1;
        if (s.phase == 2'd3) begin
          next_s.rail = s.rail + 4'd1;
          if (s.rail == 4'(NRAIL - 1)) begin
            next_s.testing = 1'b0;
            done = 1'b1;
          end
        end
      end
    end
    if (launch) begin
      next_s.testing = 1'b1;
      next_s.rail = 4'd0;
      next_s.phase = 2'd0;
      next_s.cnt = 8'h00;
      next_s.ovFlags = '0;
      next_s.uvFlags = '0;
    end

    // reference supervision per state
    case (s.st)
      ST_OFF: begin
        next_s.regOn = 1'b0;
      end
      ST_PU_TEST: begin
        if (refBad) begin
          next_s.st = ST_FAIL;
          next_s.testFail = 1'b1;
          next_s.testing = 1'b0;
        end else if (done) begin
          next_s.st = ST_ON;
          next_s.regOn = 1'b1;
        end
      end
      ST_ON, ST_DEMAND: begin
        if (done && s.st == ST_DEMAND) begin
          next_s.st = ST_ON;
        end
        if (refBad && !bypass) begin
          next_s.st = ST_FAIL;
          next_s.regOn = 1'b0;
          next_s.testing = 1'b0;
        end
      end
      ST_FAIL: begin
        next_s.regOn = 1'b0;
        if (!s.puSync[1]) begin
          next_s.st = ST_OFF;
        end
      end
      default: next_s.st = ST_OFF;
    endcase
    // sticky flag; a new failure wins over a clear
    if (refBad) begin
      next_s.irqFlag = 1'b1;
    end
    next_s.irq = next_s.irqFlag & ~next_s.irqMask;
    next_s.blank = next_s.st == ST_DEMAND;
    next_s.ovFrc = (next_s.testing && next_s.phase == 2'd0) ? NRAIL'(1) << next_s.rail : '0;
    next_s.uvFrc = (next_s.testing && next_s.phase == 2'd2) ? NRAIL'(1) << next_s.rail : '0;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{st: ST_OFF, irqMask: IRQ_MASK_RST, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign link.regAck = s.ack;
  assign link.regRdata = s.rdata;
  assign ovForce = s.ovFrc;
  assign uvForce = s.uvFrc;
  assign regEnable = s.regOn;
  assign monitorBlank = s.blank;
  assign selfTestFail = s.testFail;
  assign irqOut = s.irq;
endmodule

// *** hw/sm_host.sv ***
/*
  host controller: APB slave with a command and a status register,
  master of the register link to the safety monitor.
  assumes the monitor acks each request exactly once.
*/
`timescale 1ns/100ps
module sm_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // register link
  sm_link_if.host link
);
  import sm_pkg::*;

  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic busy;
    logic wr;
    logic rd;
    logic secure;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] lastRead;
  } host_t;

  host_t s;
  host_t next_s;
  logic access;

  always_comb begin
    next_s = s;
    access = psel & penable & ~s.ready;
    next_s.ready = access;
    next_s.slverr = 1'b0;
    next_s.rdata = 32'h0000_0000;
    if (access) begin
      case (paddr)
        H_CMD: next_s.slverr = 1'b0;
        H_STAT: begin
          next_s.rdata[S_BUSY] = s.busy;
          next_s.rdata[S_RDATA_LSB +: 8] = s.lastRead;
        end
        default: next_s.slverr = 1'b1;
      endcase
    end
    // a command lands at the edge where the master sees pready;
    // one arriving while busy is dropped, software polls busy first
    if (psel && penable && s.ready && pwrite && paddr == H_CMD && !s.busy) begin
      next_s.busy = 1'b1;
      next_s.wdata = pwdata[C_WDATA_LSB +: 8];
      next_s.addr = pwdata[C_ADDR_LSB +: 4];
      next_s.wr = pwdata[C_WRITE];
      next_s.rd = ~pwdata[C_WRITE];
      next_s.secure = pwdata[C_SECURE];
    end
    if (s.busy && link.regAck) begin
      next_s.busy = 1'b0;
      next_s.wr = 1'b0;
      next_s.rd = 1'b0;
      if (s.rd) begin
        next_s.lastRead = link.regRdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.slverr;
  assign link.regAddr = s.addr;
  assign link.regWdata = s.wdata;
  assign link.regWr = s.wr;
  assign link.regRd = s.rd;
  assign link.regSecure = s.secure;
endmodule

// *** tb/sm_monitor_sva.sv ***
/*
  assertions on the register link and the monitor outputs.
  assumes the bench instantiates it beside the link it watches.
*/
`timescale 1ns/100ps
module sm_monitor_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // link
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic regAck,
  // monitor side
  input wire logic refMismatchIn,
  input wire logic bypassCfgIn,
  input wire logic regEnable,
  input wire logic monitorBlank,
  input wire logic [sm_pkg::NRAIL-1:0] ovForce,
  input wire logic [sm_pkg::NRAIL-1:0] uvForce
);
  import sm_pkg::*;
  logic [11:0] blankCnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // length of the current blanking window
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) blankCnt <= 12'h0;
    else if (monitorBlank) blankCnt <= blankCnt + 12'h1;
    else blankCnt <= 12'h0;
  end
  ack_pulse_a: assert property (regAck |=> !regAck)
    else $error("ack longer than one cycle");
  ack_delay_a: assert property ((regWr || regRd) && !regAck |=> regAck)
    else $error("link request not acked in one cycle");
  req_hold_a: assert property ((regWr || regRd) && !regAck |=>
    $stable({regAddr, regWdata, regWr, regRd})) else $error("request changed before ack");
  rd_wr_excl_a: assert property (!(regWr && regRd)) else $error("read and write together");
  force_onehot_a: assert property ($onehot0({ovForce, uvForce}))
    else $error("more than one comparator forced");
  blank_bound_a: assert property (blankCnt <= 12'(BLANK_MAX_CYC))
    else $error("blanking too long");
  blank_force_a: assert property ($rose(monitorBlank) |-> ##[0:3] (|ovForce))
    else $error("test started without forcing");
  drift_shut_a: assert property ((refMismatchIn && !bypassCfgIn) [*5] |=> !regEnable)
    else $error("drift left regulators on");
  bypass_keep_a: assert property ((regEnable && bypassCfgIn) [*4] |=> regEnable)
    else $error("bypassed drift shut regulators");
  cover property ($rose(monitorBlank));
  cover property ($fell(regEnable));
  cover property (regAck && regWr);
endmodule

// *** tb/tb_safety_monitor_selftest.sv ***
/*
  bench for host controller and safety monitor joined by the link.
  assumes healthy comparators follow their force input.
*/
`timescale 1ns/100ps
module tb_safety_monitor_selftest;
  import sm_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00, rd;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic refMismatchIn = 1'b0, powerUpReqIn = 1'b0, bypassCfgIn = 1'b0, secureEnIn = 1'b0;
  logic [NRAIL-1:0] ovBad = '0, uvBad = '0, ovForce, uvForce, ovCmpIn, uvCmpIn;
  logic regEnable, monitorBlank, selfTestFail, irqOut;
  int fails = 0, samples_checked = 0, cyc = 0;
  sm_link_if link();
  // a dead comparator sticks low
  assign ovCmpIn = ovForce & ~ovBad;
  assign uvCmpIn = uvForce & ~uvBad;
  always #50 ref_clk = ~ref_clk;
  sm_host u_sm_host (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  sm_device u_sm_device (.ref_clk(ref_clk), .rstn(rstn), .link(link),
    .refMismatchIn(refMismatchIn), .ovCmpIn(ovCmpIn), .uvCmpIn(uvCmpIn), .ovForce(ovForce),
    .uvForce(uvForce), .powerUpReqIn(powerUpReqIn), .bypassCfgIn(bypassCfgIn),
    .secureEnIn(secureEnIn), .regEnable(regEnable), .monitorBlank(monitorBlank),
    .selfTestFail(selfTestFail), .irqOut(irqOut));
  sm_monitor_sva u_sm_monitor_sva (.ref_clk(ref_clk), .rstn(rstn), .regAddr(link.regAddr),
    .regWdata(link.regWdata), .regWr(link.regWr), .regRd(link.regRd), .regAck(link.regAck),
    .refMismatchIn(refMismatchIn), .bypassCfgIn(bypassCfgIn), .regEnable(regEnable),
    .monitorBlank(monitorBlank), .ovForce(ovForce), .uvForce(uvForce));

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one device access through the command register, then poll until idle
  task automatic dev(input logic w, input logic s, input logic [3:0] a, input logic [7:0] d);
    logic [31:0] c;
    c = 32'h0;
    c[7:0] = d;
    c[11:8] = a;
    c[C_WRITE] = w;
    c[C_SECURE] = s;
    apb(1'b1, H_CMD, c);
    r = 32'h1;
    for (int i = 0; i < 20 && r[S_BUSY] !== 1'b0; i++) apb(1'b0, H_STAT, 32'h0);
    rd = r[15:8];
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    dev(1'b0, 1'b0, a, 8'h00);
    chk(rd, e);
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  initial begin
    waitc(10);
    rstn <= 1'b1;
    ovBad <= 11'h004;
    uvBad <= 11'h100;
    powerUpReqIn <= 1'b1;
    for (int i = 0; i < 3000 && regEnable !== 1'b1; i++) @(posedge ref_clk);
    chk({7'h0, regEnable}, 8'h01);
    rdchk(A_SW_OV, 8'h04);
    rdchk(A_LIN_UV, 8'h02);
    rdchk(A_SW_UV, 8'h00);
    rdchk(A_LIN_OV, 8'h00);
    rdchk(A_IRQ_MASK, 8'h00);
    apb(1'b0, 8'h08, 32'h0);
    chk({7'h0, err}, 8'h01);
    $display("power-up test done");
    secureEnIn <= 1'b1;
    dev(1'b1, 1'b0, A_SW_OV, 8'hff);
    rdchk(A_SW_OV, 8'h04);
    dev(1'b1, 1'b0, A_CTRL, 8'h01);
    rdchk(A_CTRL, 8'h00);
    dev(1'b1, 1'b1, A_SW_OV, 8'hff);
    rdchk(A_SW_OV, 8'h00);
    $display("secure write test done");
    rdchk(A_STATUS, 8'h04);
    ovBad <= '0;
    uvBad <= 11'h001;
    dev(1'b1, 1'b1, A_CTRL, 8'h01);
    rdchk(A_CTRL, 8'h01);
    chk({7'h0, monitorBlank}, 8'h01);
    dev(1'b1, 1'b1, A_CTRL, 8'h00);
    dev(1'b1, 1'b1, A_CTRL, 8'h01);
    rdchk(A_CTRL, 8'h01);
    for (int i = 0; i < 2100 && monitorBlank !== 1'b0; i++) @(posedge ref_clk);
    rdchk(A_CTRL, 8'h00);
    rdchk(A_SW_UV, 8'h01);
    rdchk(A_LIN_UV, 8'h00);
    ovBad <= 11'h080;
    uvBad <= '0;
    dev(1'b1, 1'b1, A_CTRL, 8'h01);
    rdchk(A_CTRL, 8'h01);
    for (int i = 0; i < 2100 && monitorBlank !== 1'b0; i++) @(posedge ref_clk);
    rdchk(A_SW_UV, 8'h00);
    rdchk(A_LIN_OV, 8'h01);
    dev(1'b1, 1'b1, A_LIN_OV, 8'h01);
    rdchk(A_LIN_OV, 8'h00);
    $display("on-demand test done");
    bypassCfgIn <= 1'b1;
    waitc(2);
    refMismatchIn <= 1'b1;
    waitc(6);
    rdchk(A_STATUS, 8'h07);
    chk({7'h0, irqOut}, 8'h01);
    refMismatchIn <= 1'b0;
    waitc(6);
    dev(1'b1, 1'b0, A_STATUS, 8'h02);
    rdchk(A_STATUS, 8'h04);
    dev(1'b1, 1'b0, A_IRQ_MASK, 8'h01);
    refMismatchIn <= 1'b1;
    waitc(6);
    chk({7'h0, irqOut}, 8'h00);
    rdchk(A_STATUS, 8'h07);
    refMismatchIn <= 1'b0;
    waitc(6);
    $display("bypassed drift test done");
    bypassCfgIn <= 1'b0;
    waitc(2);
    refMismatchIn <= 1'b1;
    waitc(8);
    chk({7'h0, regEnable}, 8'h00);
    refMismatchIn <= 1'b0;
    powerUpReqIn <= 1'b0;
    waitc(6);
    $display("shutdown drift test done");
    refMismatchIn <= 1'b1;
    powerUpReqIn <= 1'b1;
    waitc(50);
    chk({6'h0, selfTestFail, regEnable}, 8'h00);
    refMismatchIn <= 1'b0;
    waitc(100);
    bypassCfgIn <= 1'b1;
    refMismatchIn <= 1'b1;
    waitc(8);
    chk({6'h0, selfTestFail, regEnable}, 8'h02);
    $display("blocked power-up test done");
    results();
  end
endmodule
